// file: src/dbs_sizer.sv
`timescale 1ns/100ps
module dbs_sizer (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic op_start,
   input wire logic [1:0] op_kind,
   input wire logic [31:0] op_addr,
   input wire logic [7:0] op_wdata,
   output logic op_busy,
   output logic op_done,
   output logic [31:0] op_rdata,
   output logic bus_strobe,
   output logic bus_write,
   output logic bus_lock,
   output logic [29:0] bus_base,
   output logic remaining_size_hi,
   output logic remaining_size_lo,
   output logic byte_offset_hi,
   output logic byte_offset_lo,
   output logic [31:0] data_out,
   output logic data_oe_b,
   input wire logic [31:0] data_in,
   input wire logic port_ack_hi_b,
   input wire logic port_ack_lo_b
);
   dbs_pkg::dbs_state_t state_r, state_nxt;
   logic [2:0] cnt_r;
   logic [1:0] ofs_r;
   logic [1:0] kind_r;
   logic [7:0] mask_r;
   logic [7:0] asm_r [4];
   logic [7:0] asm_nxt [4];
   logic busy_r, done_r, strobe_r, write_r, lock_r, oe_b_r;
   logic [29:0] base_r;
   logic [31:0] rdata_r, dout_r;

   // Bytes a completed cycle accepts, by port width and alignment
   function automatic logic [2:0] acc_bytes(input logic [1:0] ack,
                                            input logic [2:0] cnt,
                                            input logic [1:0] ofs);
      acc_bytes = 3'h0;
      case (ack)
         dbs_pkg::ACK_PORT32: acc_bytes = cnt;
         dbs_pkg::ACK_PORT16: begin
            if (ofs[0] || cnt == dbs_pkg::CNT_BYTE) begin
               acc_bytes = dbs_pkg::CNT_BYTE;
            end else begin
               acc_bytes = dbs_pkg::CNT_PAIR;
            end
         end
         dbs_pkg::ACK_PORT8: acc_bytes = dbs_pkg::CNT_BYTE;
         default: acc_bytes = 3'h0;
      endcase
   endfunction

   // One byte at its operand position, others zero
   function automatic logic [31:0] place_byte(input logic [7:0] b,
                                              input logic [1:0] ofs);
      place_byte = 32'h0;
      place_byte[{~ofs, 3'b000} +: 8] = b;
   endfunction

   // Acknowledge decode and cycle accounting
   wire logic [1:0] ack;
   wire logic ack_seen;
   wire logic [2:0] acc;
   wire logic last;
   wire logic rmw_turn;
   wire logic start_ok;
   wire logic [7:0] rmw_byte;
   assign ack = {port_ack_hi_b, port_ack_lo_b};
   assign ack_seen = (state_r == dbs_pkg::ST_CYCLE) &&
                     (ack != dbs_pkg::ACK_WAIT);
   assign acc = acc_bytes(ack, cnt_r, ofs_r);
   assign last = ack_seen && (cnt_r == acc);
   assign rmw_turn = last && (kind_r == dbs_pkg::KIND_RMW_BYTE) && !write_r;
   assign start_ok = (state_r == dbs_pkg::ST_IDLE) && op_start &&
                     (op_kind != 2'h3);
   assign rmw_byte = asm_nxt[ofs_r] | mask_r;

   // Read capture: each operand byte from the lane its port uses
   genvar k;
   for (k = 0; k < dbs_pkg::LANES; k++) begin : g_cap
      wire logic [1:0] lane;
      wire logic take;
      wire logic [2:0] upto;
      assign lane = (ack == dbs_pkg::ACK_PORT32) ? 2'(k) :
                    (ack == dbs_pkg::ACK_PORT16) ? {1'b0, 1'(k)} :
                    2'h0;
      assign upto = {1'b0, ofs_r} + acc;
      assign take = ack_seen && !write_r && (3'(k) >= {1'b0, ofs_r}) &&
                    (3'(k) < upto);
      assign asm_nxt[k] = take ? data_in[{~lane, 3'b000} +: 8] : asm_r[k];
      always_ff @(posedge ref_clk or negedge rst_b) begin
         if (!rst_b) begin
            asm_r[k] <= 8'h00;
         end else begin
            asm_r[k] <= asm_nxt[k];
         end
      end
   end

   // Write lane routing
   wire logic [1:0] mux_ofs;
   wire logic [31:0] mux_op;
   wire logic [31:0] mux_lanes;
   assign mux_ofs = (state_r == dbs_pkg::ST_IDLE) ? op_addr[1:0] : ofs_r;
   assign mux_op = (state_r == dbs_pkg::ST_IDLE) ?
                   place_byte(op_wdata, op_addr[1:0]) :
                   place_byte(rmw_byte, ofs_r);
   dbs_lane_mux u_mux (
      .offset(mux_ofs),
      .operand(mux_op),
      .lanes(mux_lanes)
   );

   // Sequencer next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         dbs_pkg::ST_IDLE: begin
            if (start_ok) begin
               state_nxt = dbs_pkg::ST_CYCLE;
            end
         end
         dbs_pkg::ST_CYCLE: begin
            if (last && !rmw_turn) begin
               state_nxt = dbs_pkg::ST_IDLE;
            end else if (ack_seen) begin
               state_nxt = dbs_pkg::ST_GAP;
            end
         end
         dbs_pkg::ST_GAP: state_nxt = dbs_pkg::ST_CYCLE;
         default: state_nxt = dbs_pkg::ST_IDLE;
      endcase
   end

   // Operation setup and per-cycle accounting
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= dbs_pkg::ST_IDLE;
         cnt_r <= dbs_pkg::CNT_LONG;
         ofs_r <= dbs_pkg::OFS_ALIGNED;
         kind_r <= dbs_pkg::KIND_READ_LONG;
         mask_r <= 8'h00;
         base_r <= 30'h0;
         write_r <= 1'b0;
         lock_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (start_ok) begin
            base_r <= op_addr[31:2];
            kind_r <= op_kind;
            mask_r <= op_wdata;
            write_r <= (op_kind == dbs_pkg::KIND_WRITE_BYTE);
            lock_r <= (op_kind == dbs_pkg::KIND_RMW_BYTE);
            if (op_kind == dbs_pkg::KIND_READ_LONG) begin
               cnt_r <= dbs_pkg::CNT_LONG;
               ofs_r <= dbs_pkg::OFS_ALIGNED;
            end else begin
               cnt_r <= dbs_pkg::CNT_BYTE;
               ofs_r <= op_addr[1:0];
            end
         end else if (rmw_turn) begin
            cnt_r <= dbs_pkg::CNT_BYTE;
            write_r <= 1'b1;
         end else if (ack_seen) begin
            cnt_r <= cnt_r - acc;
            ofs_r <= ofs_r + acc[1:0];
            if (last) begin
               lock_r <= 1'b0;
            end
         end
      end
   end

   // Bus strobe, data drive and completion
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_r <= 1'b0;
         done_r <= 1'b0;
         strobe_r <= 1'b0;
         oe_b_r <= 1'b1;
         dout_r <= 32'h0;
         rdata_r <= 32'h0;
      end else begin
         done_r <= last && !rmw_turn;
         if (start_ok) begin
            busy_r <= 1'b1;
            strobe_r <= 1'b1;
            oe_b_r <= (op_kind != dbs_pkg::KIND_WRITE_BYTE);
            dout_r <= mux_lanes;
         end else if (state_r == dbs_pkg::ST_GAP) begin
            strobe_r <= 1'b1;
            oe_b_r <= !write_r;
         end else if (ack_seen) begin
            strobe_r <= 1'b0;
            oe_b_r <= 1'b1;
            if (rmw_turn) begin
               dout_r <= mux_lanes;
               rdata_r <= place_byte(asm_nxt[ofs_r], ofs_r);
            end else if (last) begin
               busy_r <= 1'b0;
               if (!write_r) begin
                  rdata_r <= {asm_nxt[0], asm_nxt[1], asm_nxt[2],
                              asm_nxt[3]};
               end
            end
         end
      end
   end

   // Outputs straight from flops
   assign op_busy = busy_r;
   assign op_done = done_r;
   assign op_rdata = rdata_r;
   assign bus_strobe = strobe_r;
   assign bus_write = write_r;
   assign bus_lock = lock_r;
   assign bus_base = base_r;
   assign remaining_size_hi = cnt_r[1];
   assign remaining_size_lo = cnt_r[0];
   assign byte_offset_hi = ofs_r[1];
   assign byte_offset_lo = ofs_r[0];
   assign data_out = dout_r;
   assign data_oe_b = oe_b_r;

   // Checks
   wire logic [1:0] size_w;
   assign size_w = {remaining_size_hi, remaining_size_lo};

   sequence s_next_cycle(logic [1:0] sz, logic [1:0] of);
      !bus_strobe ##1 (bus_strobe && size_w == sz &&
                       {byte_offset_hi, byte_offset_lo} == of);
   endsequence

   property p_long_start;
      @(posedge ref_clk) disable iff (!rst_b)
      start_ok && op_kind == dbs_pkg::KIND_READ_LONG |=>
         bus_strobe && size_w == 2'h0 && !byte_offset_hi && !byte_offset_lo;
   endproperty
   a_long_start: assert property (p_long_start)
      else $error("long read does not start aligned long");

   property p_word_follow;
      @(posedge ref_clk) disable iff (!rst_b)
      ack_seen && ack == dbs_pkg::ACK_PORT16 && size_w == 2'h0 &&
         ofs_r == 2'h0 && !write_r |=> s_next_cycle(2'h2, 2'h2);
   endproperty
   a_word_follow: assert property (p_word_follow)
      else $error("16-bit follow-on cycle not size 10 offset 10");

   property p_byte_follow;
      @(posedge ref_clk) disable iff (!rst_b)
      ack_seen && ack == dbs_pkg::ACK_PORT8 && size_w == 2'h0 &&
         !write_r |=> s_next_cycle(2'h3, 2'h1);
   endproperty
   a_byte_follow: assert property (p_byte_follow)
      else $error("8-bit second cycle not three bytes at offset 1");

   property p_write_drive;
      @(posedge ref_clk) disable iff (!rst_b)
      bus_strobe && bus_write |-> !data_oe_b;
   endproperty
   a_write_drive: assert property (p_write_drive)
      else $error("write cycle without data drive");

   property p_byte_lanes;
      @(posedge ref_clk) disable iff (!rst_b)
      bus_strobe && bus_write && byte_offset_hi && byte_offset_lo |->
         data_out[31:24] == data_out[7:0] &&
         data_out[23:16] == data_out[7:0] && data_out[15:8] == data_out[7:0];
   endproperty
   a_byte_lanes: assert property (p_byte_lanes)
      else $error("byte at offset 3 not on every lane");

   property p_done_32;
      @(posedge ref_clk) disable iff (!rst_b)
      ack_seen && ack == dbs_pkg::ACK_PORT32 && size_w == 2'h0 &&
         !write_r |=> op_done && !op_busy && op_rdata == $past(data_in);
   endproperty
   a_done_32: assert property (p_done_32)
      else $error("32-bit long read not delivered next cycle");

   property p_count_down;
      @(posedge ref_clk) disable iff (!rst_b)
      ack_seen && !last |=> cnt_r == $past(cnt_r) - $past(acc);
   endproperty
   a_count_down: assert property (p_count_down)
      else $error("remaining count not lowered by accepted bytes");

   property p_wait_hold;
      @(posedge ref_clk) disable iff (!rst_b)
      state_r == dbs_pkg::ST_CYCLE && ack == dbs_pkg::ACK_WAIT |=>
         bus_strobe && $stable(size_w) && !op_done;
   endproperty
   a_wait_hold: assert property (p_wait_hold)
      else $error("wait acknowledge did not hold the cycle");
endmodule // dbs_sizer

// file: shared/dbs_pkg.sv
package dbs_pkg;
   // Remaining-size codes on the size outputs
   localparam logic [1:0] SIZE_LONG = 2'h0;
   localparam logic [1:0] SIZE_BYTE = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [1:0] SIZE_3BYTE = 2'h3;
   // Port acknowledge pair {hi, lo}, active-low levels as on the bus
   localparam logic [1:0] ACK_WAIT = 2'h3;
   localparam logic [1:0] ACK_PORT8 = 2'h2;
   localparam logic [1:0] ACK_PORT16 = 2'h1;
   localparam logic [1:0] ACK_PORT32 = 2'h0;
   // Operation kinds started by the table-search logic
   localparam logic [1:0] KIND_READ_LONG = 2'h0;
   localparam logic [1:0] KIND_WRITE_BYTE = 2'h1;
   localparam logic [1:0] KIND_RMW_BYTE = 2'h2;
   // Byte counts and offsets
   localparam logic [2:0] CNT_LONG = 3'h4;
   localparam logic [2:0] CNT_BYTE = 3'h1;
   localparam logic [2:0] CNT_PAIR = 3'h2;
   localparam logic [1:0] OFS_ALIGNED = 2'h0;
   localparam int LANES = 4;
   // Bus cycle sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CYCLE = 3'b010,
      ST_GAP = 3'b100
   } dbs_state_t;
endpackage

// file: src/dbs_lane_mux.sv
`timescale 1ns/100ps
module dbs_lane_mux (
   input wire logic [1:0] offset,
   input wire logic [31:0] operand,
   output logic [31:0] lanes
);
   // Source operand byte for a lane, lane 0 being the top lane
   function automatic logic [1:0] src_byte(input logic [1:0] lane,
                                           input logic [1:0] ofs);
      logic [2:0] span;
      logic [2:0] sum;
      span = 3'h4 - {1'b0, ofs};
      sum = {1'b0, ofs} + ({1'b0, lane} % span);
      if (lane >= ofs) begin
         src_byte = lane;
      end else begin
         src_byte = sum[1:0];
      end
   endfunction

   // Route operand bytes onto the four lanes
   genvar g;
   for (g = 0; g < dbs_pkg::LANES; g++) begin : g_lane
      wire logic [1:0] src;
      assign src = src_byte(2'(g), offset);
      assign lanes[31 - 8 * g -: 8] = operand[{~src, 3'b000} +: 8];
   end
endmodule // dbs_lane_mux

// file: testbench/dbs_mem_model.sv
`timescale 1ns/100ps
module dbs_mem_model (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [1:0] port_code,
   input wire logic [1:0] wait_n,
   input wire logic load_en,
   input wire logic [31:0] load_word,
   input wire logic bus_strobe,
   input wire logic bus_write,
   input wire logic [1:0] ofs,
   input wire logic [31:0] data_out,
   output logic [31:0] data_in,
   output logic port_ack_hi_b,
   output logic port_ack_lo_b,
   output logic [31:0] mem_word
);
   logic [1:0] cnt_r;
   logic [31:0] last_r;
   logic [31:0] rd_lanes;
   logic [1:0] wsel;
   logic ack_now;
   // Ack after the wait count, always the port width
   assign ack_now = bus_strobe && (cnt_r >= wait_n);
   assign {port_ack_hi_b, port_ack_lo_b} =
      ack_now ? port_code : dbs_pkg::ACK_WAIT;
   // Port sits on fixed lanes; undriven lanes toggle
   always_comb begin
      rd_lanes = ~last_r;
      case (port_code)
         dbs_pkg::ACK_PORT32: rd_lanes = mem_word;
         dbs_pkg::ACK_PORT16: rd_lanes[31:16] = mem_word[31-16*ofs[1] -: 16];
         default: rd_lanes[31:24] = mem_word[31-8*ofs -: 8];
      endcase
   end
   assign data_in = (bus_strobe && !bus_write) ? rd_lanes : ~last_r;
   // Only the active lane of the port is enabled on writes
   assign wsel = (port_code == dbs_pkg::ACK_PORT32) ? ofs :
      (port_code == dbs_pkg::ACK_PORT16) ? {1'b0, ofs[0]} : 2'h0;
   // Wait counter, toggle history and memory
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= 2'h0;
         last_r <= 32'h0;
         mem_word <= 32'h0;
      end else begin
         last_r <= data_in;
         cnt_r <= (bus_strobe && !ack_now) ? cnt_r + 2'h1 : 2'h0;
         if (load_en)
            mem_word <= load_word;
         if (ack_now && bus_write)
            mem_word[31-8*ofs -: 8] <= data_out[31-8*wsel -: 8];
      end
   end
endmodule // dbs_mem_model

// file: testbench/tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
   failures++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb_top;
   logic ref_clk = 0, rst_b = 0, op_start = 0, load_en = 0;
   logic [1:0] op_kind = 0, port_code = 0, wait_n = 0;
   logic [31:0] op_addr = 0, load_word = 0, data_in, data_out, op_rdata;
   logic [7:0] op_wdata = 0;
   logic op_busy, op_done, bus_strobe, bus_write, bus_lock, data_oe_b;
   logic sh, sl, oh, ol, ahb, alb;
   logic [29:0] bus_base, cur_base = 0;
   logic [31:0] mem_word, shadow = 0, last_rd = 0;
   logic [37:0] cq[$];
   logic [63:0] dq[$];
   logic [37:0] ce;
   logic [63:0] de;
   integer seed = 32'hde50;
   int failures = 0, total_checks = 0;
   always #12.5 ref_clk = ~ref_clk;
   dbs_sizer i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .op_start(op_start),
      .op_kind(op_kind), .op_addr(op_addr), .op_wdata(op_wdata),
      .op_busy(op_busy), .op_done(op_done), .op_rdata(op_rdata),
      .bus_strobe(bus_strobe), .bus_write(bus_write), .bus_lock(bus_lock),
      .bus_base(bus_base), .remaining_size_hi(sh), .remaining_size_lo(sl),
      .byte_offset_hi(oh), .byte_offset_lo(ol), .data_out(data_out),
      .data_oe_b(data_oe_b), .data_in(data_in), .port_ack_hi_b(ahb),
      .port_ack_lo_b(alb));
   dbs_mem_model i_mem (.ref_clk(ref_clk), .rst_b(rst_b),
      .port_code(port_code), .wait_n(wait_n), .load_en(load_en),
      .load_word(load_word), .bus_strobe(bus_strobe), .bus_write(bus_write),
      .ofs({oh, ol}), .data_out(data_out), .data_in(data_in),
      .port_ack_hi_b(ahb), .port_ack_lo_b(alb), .mem_word(mem_word));
   task give_verdict;
      if (failures == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Expected write lanes for a byte at offset o
   function automatic logic [31:0] wlanes(input logic [1:0] o,
      input logic [7:0] b);
      logic [31:0] r;
      int s;
      r = 32'h0;
      for (int l = 0; l < 4; l++) begin
         s = (l >= o) ? l : o + l % (4 - o);
         if (s == o)
            r[31-8*l -: 8] = b;
      end
      return r;
   endfunction
   // One operation: drive, note the bus cycles and result, wait done
   task automatic run_op(input logic [1:0] k, input logic [1:0] o,
      input logic [1:0] pc, input logic [1:0] wt, input bit poke);
      logic [2:0] cnt;
      logic [1:0] of;
      logic [7:0] wd, wb;
      logic [31:0] w, rd;
      int n;
      w = $random(seed);
      wd = $random(seed);
      @(posedge ref_clk);
      port_code <= pc;
      wait_n <= wt;
      op_kind <= k;
      op_wdata <= wd;
      op_addr <= {w[31:2], o};
      op_start <= 1'b1;
      cur_base = w[31:2];
      if (k == dbs_pkg::KIND_READ_LONG) begin
         load_word <= w;
         load_en <= 1'b1;
         shadow = w;
      end
      of = (k == dbs_pkg::KIND_READ_LONG) ? 2'h0 : o;
      cnt = (k == dbs_pkg::KIND_READ_LONG) ? 3'h4 : 3'h1;
      rd = last_rd;
      wb = shadow[31-8*of -: 8];
      while (k != dbs_pkg::KIND_WRITE_BYTE && cnt != 0) begin
         cq.push_back({k == dbs_pkg::KIND_RMW_BYTE, 1'b0, cnt[1:0], of,
            32'h0});
         n = (pc == dbs_pkg::ACK_PORT32) ? cnt : (pc == dbs_pkg::ACK_PORT16
            && !of[0] && cnt != 1) ? 2 : 1;
         cnt = cnt - 3'(n);
         of = of + 2'(n);
      end
      if (k == dbs_pkg::KIND_READ_LONG)
         rd = shadow;
      if (k == dbs_pkg::KIND_RMW_BYTE)
         rd = 32'(wb) << (8 * (3 - o));
      if (k != dbs_pkg::KIND_READ_LONG) begin
         wb = (k == dbs_pkg::KIND_RMW_BYTE) ? wb | wd : wd;
         cq.push_back({k == dbs_pkg::KIND_RMW_BYTE, 1'b1, 2'h1, o,
            wlanes(o, wb)});
         shadow[31-8*o -: 8] = wb;
      end
      dq.push_back({rd, shadow});
      last_rd = rd;
      @(posedge ref_clk);
      load_en <= 1'b0;
      op_start <= poke;
      op_kind <= dbs_pkg::KIND_WRITE_BYTE;
      @(posedge ref_clk);
      op_start <= 1'b0;
      n = 0;
      while (op_done !== 1'b1 && n < 200) begin
         @(posedge ref_clk);
         n++;
      end
      if (n == 200) `CHK("done wait", 1'b1, 1'b0)
   endtask
   // Scoreboard on completed bus cycles and finished operations
   always @(posedge ref_clk) begin
      if (bus_strobe === 1'b1 && {ahb, alb} !== dbs_pkg::ACK_WAIT) begin
         if (cq.size() == 0) `CHK("spare cycle", 1'b0, 1'b1)
         else begin
            ce = cq.pop_front();
            `CHK("size ofs", ce[35:32], {sh, sl, oh, ol})
            `CHK("lock wr", ce[37:36], {bus_lock, bus_write})
            `CHK("base", cur_base, bus_base)
            if (ce[36])
               `CHK("wlanes", {1'b0, ce[31:0]}, {data_oe_b, data_out})
         end
      end
      if (op_done === 1'b1) begin
         if (dq.size() == 0) `CHK("spare done", 1'b0, 1'b1)
         else begin
            de = dq.pop_front();
            `CHK("rdata", de[63:32], op_rdata)
            `CHK("memory", de[31:0], mem_word)
         end
      end
   end
   // Main sequence: every kind on every port, random offsets and waits
   initial begin
      repeat (12) @(posedge ref_clk);
      `CHK("reset", 6'h01, {op_busy, op_done, bus_strobe, sh, sl, data_oe_b})
      rst_b <= 1'b1;
      for (int i = 0; i < 45; i++)
         run_op(2'(i % 3), 2'($random(seed)), 2'(2 - (i / 3) % 3),
            2'($random(seed)), i % 4 == 1);
      @(posedge ref_clk);
      op_kind <= 2'h3;
      op_start <= 1'b1;
      @(posedge ref_clk);
      op_start <= 1'b0;
      repeat (6) @(posedge ref_clk);
      `CHK("kind3 busy", 1'b0, op_busy)
      `CHK("notes left", 0, cq.size() + dq.size())
      give_verdict;
   end
   // Watchdog against a hung operation
   initial begin
      #500000;
      failures++;
      give_verdict;
   end
endmodule // tb_top
